// [core/indicator_led_ctrl.sv]
/*
  indicator led control: green flash array, blue aiming pattern and the
  row of five status leds, driven from read-cycle and match events.
  assumes event inputs are synchronous pulses or levels from the read
  logic and that configuration fields are stable between changes.
*/
// How it works
// [R01] flash mode codes: off, good read, static, match, mismatch, strobe.
// [R02] flash mode off keeps the green array dark always.
// [R03] good read mode flashes on good read or enabled match.
// [R04] static mode with free run: red while searching, green for hold.
// [R05] during static hold only one read accepted unless several symbols.
// [R06] static mode without free-running reading never flashes green.
// [R07] match mode flashes on match; all must match; no compare: good read.
// [R08] mismatch mode flashes on mismatch, any symbol; no compare: never flashes.
// [R09] strobe mode pulses green at capture; internal light may be off.
// [R10] aim codes: off, outside cycle, inside cycle, always on.
// [R11] aim off stays dark unless the override is asserted.
// [R12] aim setting 1 lit outside the cycle; override keeps it lit.
// [R13] aim setting 2 lit inside the cycle only; override keeps it lit.
// [R14] green hold lasts the programmed count of 10 ms steps.
// [R15] status mode standard or grade of first matrix symbol in cycle.
// [R16] grade bar lights from lowest: five lit is A, one is F.
// [R17] standard mode shows cycle activity and good read at cycle end.
// [R18] in standard mode the read rate test shows good-read percentage on the status bar.
// [R19] graded parameter: final, contrast, growth, axial, unused ecc.
// [R20] a 10 ms tick restarts at each trigger and the hold expires.
`timescale 1ns/100ps
module indicator_led_ctrl #(
  parameter int TICK_CYCLES = indicator_pkg::TICK_CYCLES,
  parameter int NSTAT       = indicator_pkg::NUM_STATUS
) (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire indicator_pkg::cfg_t      cfg,
  input  wire indicator_pkg::read_evt_t evt,
  input  wire indicator_pkg::grades_t   grades,
  input  wire logic                     aim_override,
  input  wire logic                     rate_test,
  input  wire logic [6:0]               rate_pct,
  output logic                          green_led_r,
  output logic                          red_led_r,
  output logic                          aim_led_r,
  output logic                          illum_en_r,
  output logic                          read_accept_r,
  output logic                          cycle_led_r,
  output logic                          good_read_led_r,
  output logic [NSTAT-1:0]              status_leds_r
);

  // ****************************************
  // mode decode
  // ****************************************
  wire is_off      = cfg.flash_mode == indicator_pkg::FLASH_OFF;
  wire is_good     = cfg.flash_mode == indicator_pkg::FLASH_GOOD;
  wire is_static   = cfg.flash_mode == indicator_pkg::FLASH_STATIC;
  wire is_match    = cfg.flash_mode == indicator_pkg::FLASH_MATCH;
  wire is_mismatch = cfg.flash_mode == indicator_pkg::FLASH_MISMATCH;
  wire is_strobe   = cfg.flash_mode == indicator_pkg::FLASH_STROBE;
  wire multi_sym   = cfg.symbols_per_cycle > 4'h1;
  // static only works alongside free-running reading
  wire static_ok   = is_static && cfg.continuous_read; // R06

  // ****************************************
  // trigger selection
  // ****************************************
  wire trig_good  = evt.good_read || (cfg.match_enable && evt.match); // R03
  // several symbols: judged once at cycle end, when all are known
  wire match_hit  = multi_sym ? (evt.cycle_done && evt.all_match)
                              : evt.match;
  wire trig_match = cfg.match_enable ? match_hit : evt.good_read; // R07
  wire miss_hit   = multi_sym ? (evt.cycle_done && evt.any_mismatch)
                              : evt.mismatch;
  wire trig_miss  = cfg.match_enable && miss_hit; // R08
  wire trig_stat  = static_ok && evt.good_read && read_accept_r; // R04

  logic flash_trig;
  always_comb
  begin
    case (cfg.flash_mode) // R01
      indicator_pkg::FLASH_OFF:      flash_trig = 1'b0; // R02
      indicator_pkg::FLASH_GOOD:     flash_trig = trig_good;
      indicator_pkg::FLASH_STATIC:   flash_trig = trig_stat;
      indicator_pkg::FLASH_MATCH:    flash_trig = trig_match;
      indicator_pkg::FLASH_MISMATCH: flash_trig = trig_miss;
      indicator_pkg::FLASH_STROBE:   flash_trig = 1'b0;
      default:                       flash_trig = 1'b0;
    endcase
  end

  // ****************************************
  // green hold timer
  // ****************************************
  wire hold_active;

  hold_timer #(
    .TICK_CYCLES (TICK_CYCLES),
    .HOLD_W      (16)
  ) u_hold (
    .clk      (clk),
    .reset_n  (reset_n),
    .start    (flash_trig), // R20
    .hold_val (cfg.flash_hold),
    .active   (hold_active)
  );

  // gating by mode drops a running hold at once on a change to a mode without a hold
  wire hold_mode = is_good || static_ok || is_match || is_mismatch;
  wire green_nxt = is_strobe ? evt.capture // R09
                 : (hold_mode && hold_active && !is_off); // R14 R02 R06

  // searching means free run with no green hold showing
  wire red_nxt = static_ok && !hold_active; // R04
  // single-symbol static presentation takes one read per hold
  wire accept_nxt = !(static_ok && hold_active && !multi_sym); // R05
  // strobe mode can leave the green array as the only light source
  wire illum_nxt = !(is_strobe && cfg.illum_disable); // R09

  // ****************************************
  // aiming pattern
  // ****************************************
  logic aim_nxt;
  always_comb
  begin
    case (cfg.aim_mode) // R10
      indicator_pkg::AIM_OFF:     aim_nxt = aim_override; // R11
      indicator_pkg::AIM_OUTSIDE: aim_nxt = aim_override ||
                                            !evt.cycle_active; // R12
      indicator_pkg::AIM_INSIDE:  aim_nxt = aim_override ||
                                            evt.cycle_active; // R13
      indicator_pkg::AIM_ON:      aim_nxt = 1'b1;
      default:                    aim_nxt = 1'b1;
    endcase
  end

  // ****************************************
  // status leds
  // ****************************************
  logic                  cyc_d_r;
  logic                  grade_held_r;
  indicator_pkg::grade_t held_grade_r;
  wire cycle_start = evt.cycle_active && !cyc_d_r;
  wire grade_mode  = cfg.led_mode == indicator_pkg::LED_GRADE; // R15

  indicator_pkg::grade_t sel_grade;
  always_comb
  begin
    case (cfg.grade_param) // R19
      indicator_pkg::GP_FINAL:    sel_grade = grades.final_g;
      indicator_pkg::GP_CONTRAST: sel_grade = grades.contrast;
      indicator_pkg::GP_GROWTH:   sel_grade = grades.growth;
      indicator_pkg::GP_AXIAL:    sel_grade = grades.axial;
      indicator_pkg::GP_ECC:      sel_grade = grades.ecc;
      default:                    sel_grade = grades.final_g;
    endcase
  end

  // only the first graded symbol of a cycle counts; a grade arriving with
  // the cycle start belongs to the new cycle and is kept
  wire grade_take = grades.valid && (!grade_held_r || cycle_start); // R15
  wire held_nxt   = grade_take || (grade_held_r && !cycle_start);

  // a good read flagged at cycle end outranks a same-cycle restart
  wire gr_set  = evt.cycle_done && evt.cycle_good; // R17
  wire gr_nxt  = gr_set || (good_read_led_r && !cycle_start);

  logic [NSTAT-1:0] bar;

  level_bar #(
    .N (NSTAT)
  ) u_bar (
    .use_grade (grade_mode),
    .grade     (held_grade_r),
    .pct       (rate_pct),
    .bar       (bar)
  );

  wire [NSTAT-1:0] stat_nxt =
      grade_mode ? (grade_held_r ? bar : '0) // R16
    : (rate_test ? bar : '0); // R18

  // ****************************************
  // output registers
  // ****************************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      green_led_r   <= 1'b0;
      red_led_r     <= 1'b0;
      illum_en_r    <= 1'b1;
      read_accept_r <= 1'b1;
      aim_led_r     <= 1'b0;
    end
    else
    begin
      green_led_r   <= green_nxt;
      red_led_r     <= red_nxt;
      illum_en_r    <= illum_nxt;
      read_accept_r <= accept_nxt;
      aim_led_r     <= aim_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cyc_d_r         <= 1'b0;
      cycle_led_r     <= 1'b0;
      good_read_led_r <= 1'b0;
      grade_held_r    <= 1'b0;
      held_grade_r    <= indicator_pkg::GRADE_F;
      status_leds_r   <= '0;
    end
    else
    begin
      cyc_d_r         <= evt.cycle_active;
      cycle_led_r     <= !grade_mode && evt.cycle_active; // R17
      good_read_led_r <= !grade_mode && gr_nxt;
      grade_held_r    <= held_nxt;
      if (grade_take)
        held_grade_r  <= sel_grade;
      status_leds_r   <= stat_nxt;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_good_trig;
    (is_good && evt.good_read && cfg.flash_hold != '0) ##1 is_good;
  endsequence

  sequence s_match_trig;
    (is_match && cfg.match_enable && !multi_sym && evt.match
     && cfg.flash_hold != '0) ##1 is_match;
  endsequence

  sequence s_all_match;
    (is_match && cfg.match_enable && multi_sym && evt.cycle_done
     && evt.all_match && cfg.flash_hold != '0) ##1 is_match;
  endsequence

  sequence s_miss_trig;
    (is_mismatch && cfg.match_enable && !multi_sym && evt.mismatch
     && cfg.flash_hold != '0) ##1 is_mismatch;
  endsequence

  sequence s_stat_trig;
    (static_ok && evt.good_read && read_accept_r
     && cfg.flash_hold != '0) ##1 static_ok;
  endsequence

  a_off_dark: assert property (is_off |=> !green_led_r) // R02
    else $error("green lit while flash mode off");

  a_good_flash: assert property (s_good_trig |=> green_led_r) // R03
    else $error("no green after good read");

  a_static_nofree: assert property ( // R06
    is_static && !cfg.continuous_read |=> !green_led_r)
    else $error("static flash without free-running read");

  a_static_red: assert property ( // R04
    static_ok && !hold_active |=> red_led_r && !green_led_r)
    else $error("red not shown while searching");

  a_static_one: assert property ( // R05
    static_ok && hold_active && !multi_sym |=> !read_accept_r)
    else $error("second read accepted during hold");

  a_strobe_cap: assert property ( // R09
    is_strobe |=> green_led_r == $past(evt.capture))
    else $error("strobe does not follow capture");

  a_aim_off: assert property ( // R11
    cfg.aim_mode == indicator_pkg::AIM_OFF && !aim_override |=> !aim_led_r)
    else $error("aim lit while off");

  a_aim_ovr: assert property (aim_override |=> aim_led_r) // R12
    else $error("override did not light aim");

  a_aim_inside: assert property ( // R13
    cfg.aim_mode == indicator_pkg::AIM_INSIDE && !aim_override
    && !evt.cycle_active |=> !aim_led_r)
    else $error("aim lit outside cycle");

  a_grade_a: assert property ( // R16
    grade_mode && grade_held_r && held_grade_r == indicator_pkg::GRADE_A
    |=> status_leds_r == '1)
    else $error("grade a not full bar");

  a_good_led: assert property ( // R17
    gr_set && !grade_mode |=> good_read_led_r)
    else $error("good read led missed");

  a_match_flash: assert property (s_match_trig |=> green_led_r) // R07
    else $error("no green after match");

  a_all_match: assert property (s_all_match |=> green_led_r) // R07
    else $error("no green after all symbols matched");

  a_miss_flash: assert property (s_miss_trig |=> green_led_r) // R08
    else $error("no green after mismatch");

  a_static_flash: assert property (s_stat_trig |=> green_led_r) // R04
    else $error("no green after static read");

  a_hold_green: assert property ( // R14
    hold_mode && hold_active |=> green_led_r)
    else $error("green dark during hold");

  a_hold_dark: assert property ( // R14
    !is_strobe && !hold_active |=> !green_led_r)
    else $error("green lit without hold");

  a_illum_off: assert property ( // R09
    is_strobe && cfg.illum_disable |=> !illum_en_r)
    else $error("internal light not disabled");

  a_aim_on: assert property ( // R10
    cfg.aim_mode == indicator_pkg::AIM_ON |=> aim_led_r)
    else $error("aim dark while always on");

  a_aim_outside: assert property ( // R12
    cfg.aim_mode == indicator_pkg::AIM_OUTSIDE
    && !evt.cycle_active |=> aim_led_r)
    else $error("aim dark outside cycle");

  a_grade_first: assert property ( // R15
    grade_held_r && !cycle_start |=> $stable(held_grade_r))
    else $error("held grade replaced within cycle");

  a_grade_growth: assert property ( // R19
    grades.valid && cycle_start
    && cfg.grade_param == indicator_pkg::GP_GROWTH
    |=> held_grade_r == $past(grades.growth))
    else $error("growth grade not taken");

  a_rate_full: assert property ( // R18
    !grade_mode && rate_test && rate_pct >= 7'h64
    |=> status_leds_r == '1)
    else $error("full rate bar not shown");

endmodule

// [core/indicator_pkg.sv]
/*
  shared types and constants of the indicator led control block.
  assumes one 25 mhz clock and configuration fields held outside.
*/
package indicator_pkg;

  // ****************************************
  // modes and settings
  // ****************************************
  typedef enum logic [2:0] {
    FLASH_OFF      = 3'h0,
    FLASH_GOOD     = 3'h1,
    FLASH_STATIC   = 3'h2,
    FLASH_MATCH    = 3'h3,
    FLASH_MISMATCH = 3'h4,
    FLASH_STROBE   = 3'h5
  } flash_mode_t;

  typedef enum logic [1:0] {
    AIM_OFF     = 2'h0,
    AIM_OUTSIDE = 2'h1,
    AIM_INSIDE  = 2'h2,
    AIM_ON      = 2'h3
  } aim_mode_t;

  typedef enum logic {
    LED_STANDARD = 1'b0,
    LED_GRADE    = 1'b1
  } led_mode_t;

  typedef enum logic [2:0] {
    GP_FINAL    = 3'h0,
    GP_CONTRAST = 3'h1,
    GP_GROWTH   = 3'h2,
    GP_AXIAL    = 3'h3,
    GP_ECC      = 3'h4
  } grade_param_t;

  typedef enum logic [2:0] {
    GRADE_A = 3'h0,
    GRADE_B = 3'h1,
    GRADE_C = 3'h2,
    GRADE_D = 3'h3,
    GRADE_F = 3'h4
  } grade_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    flash_mode_t  flash_mode;
    aim_mode_t    aim_mode;
    logic [15:0]  flash_hold;
    led_mode_t    led_mode;
    grade_param_t grade_param;
    logic [3:0]   symbols_per_cycle;
    logic         continuous_read;
    logic         match_enable;
    logic         illum_disable;
  } cfg_t;

  typedef struct packed {
    logic cycle_active;
    logic good_read;
    logic match;
    logic mismatch;
    logic cycle_done;
    logic cycle_good;
    logic all_match;
    logic any_mismatch;
    logic capture;
  } read_evt_t;

  typedef struct packed {
    logic   valid;
    grade_t final_g;
    grade_t contrast;
    grade_t growth;
    grade_t axial;
    grade_t ecc;
  } grades_t;

  // ****************************************
  // defaults and timing
  // ****************************************
  localparam flash_mode_t  DEF_FLASH_MODE = FLASH_STATIC;
  localparam aim_mode_t    DEF_AIM_MODE   = AIM_ON;
  localparam logic [15:0]  DEF_FLASH_HOLD = 16'h0019;
  localparam led_mode_t    DEF_LED_MODE   = LED_STANDARD;
  localparam grade_param_t DEF_GRADE_PAR  = GP_FINAL;
  localparam int           CLK_HZ         = 25000000;
  localparam int           TICK_MS        = 10;
  localparam int           TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
  localparam int           NUM_STATUS     = 5;
  localparam int           BAR_STEP_PCT   = 20;

endpackage

// [core/hold_timer.sv]
/*
  green hold timer: counts the hold value in ticks of its own divider.
  assumes start is a one-cycle pulse from the indicator top.
*/
`timescale 1ns/100ps
module hold_timer #(
  parameter int TICK_CYCLES = indicator_pkg::TICK_CYCLES,
  parameter int HOLD_W      = 16
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              start,
  input  wire logic [HOLD_W-1:0] hold_val,
  output logic                   active
);
  localparam int PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);

  logic [PW-1:0]     pre_r;
  logic [HOLD_W-1:0] cnt_r;
  wire               tick = (pre_r == PRE_LAST);

  // restart also resets the divider so the hold is exact, not one tick short
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_r <= '0;
      cnt_r <= '0;
    end
    else if (start)
    begin
      pre_r <= '0;
      cnt_r <= hold_val; // R20
    end
    else if (cnt_r != '0)
    begin
      pre_r <= tick ? '0 : pre_r + 1'b1;
      cnt_r <= tick ? cnt_r - 1'b1 : cnt_r; // R14
    end
  end

  assign active = (cnt_r != '0);

  a_hold_load: assert property (@(posedge clk) disable iff (!reset_n)
    start && hold_val != '0 |=> active && cnt_r == $past(hold_val)) // R20
    else $error("hold timer did not load");

  a_hold_expire: assert property (@(posedge clk) disable iff (!reset_n)
    !start && cnt_r == 1 && tick |=> !active) // R14
    else $error("hold timer did not expire");

endmodule

// [core/level_bar.sv]
/*
  maps a grade or a percentage onto a bar of status leds, lowest first.
  assumes pct is 0 to 100; combinational, the top registers the result.
*/
`timescale 1ns/100ps
module level_bar #(
  parameter int N = indicator_pkg::NUM_STATUS
) (
  input  wire logic                  use_grade,
  input  wire indicator_pkg::grade_t grade,
  input  wire logic [6:0]            pct,
  output logic [N-1:0]               bar
);
  wire [2:0] grade_lvl = 3'(N) - 3'(grade);

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_led
      wire by_pct   = pct >= 7'((i + 1) * indicator_pkg::BAR_STEP_PCT);
      wire by_grade = grade_lvl >= 3'(i + 1);
      assign bar[i] = use_grade ? by_grade : by_pct; // R16 R18
    end
  endgenerate

endmodule

// [verification/read_cycle_model.sv]
/*
  read cycle and decode result source standing in for the read logic.
  assumes the bench calls run right after a rising clock edge.
*/
`timescale 1ns/100ps
module read_cycle_model (
  input  wire logic                clk,
  output indicator_pkg::read_evt_t evt,
  output indicator_pkg::grades_t   grades
);
  initial
  begin
    evt    = '0;
    grades = '0;
  end

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  // idle grade fields show the inverse, so nothing may latch them late
  task automatic run(input logic good, input logic mt, input int lat,
                     input indicator_pkg::grades_t g1, g2);
    indicator_pkg::read_evt_t e;
    e              = '0;
    e.cycle_active = 1'b1;
    e.capture      = 1'b1;
    evt            = e;
    grades         = {1'b1, g1[14:0]};
    step();
    grades         = {1'b0, ~g1[14:0]};
    repeat (lat) step();
    e.good_read    = good;
    e.match        = good & mt;
    e.mismatch     = good & !mt;
    evt            = e;
    // second grading of the cycle: must not replace the first
    grades         = {good, g2[14:0]};
    step();
    grades         = {1'b0, ~g2[14:0]};
    e              = '0;
    e.cycle_done   = 1'b1;
    e.cycle_good   = good;
    e.all_match    = good & mt;
    e.any_mismatch = good & !mt;
    evt            = e;
    step();
    evt            = '0;
  endtask
endmodule

// [verification/tb.sv]
/*
  self-checking bench of the indicator led control block.
  assumes the read cycle model for events and a four cycle tick.
*/
`timescale 1ns/100ps
`define CHK(nm, e, s) \
  begin \
    num_checks++; \
    if ((s) !== (e)) \
    begin \
      bad_count++; \
      $display("Error %s expected %0h seen %0h", nm, e, s); \
    end \
  end
module tb;
  localparam int TICK = 4;
  logic                     clk;
  logic                     reset_n;
  indicator_pkg::cfg_t      cfg;
  indicator_pkg::cfg_t      cf;
  indicator_pkg::read_evt_t evt;
  indicator_pkg::grades_t   grades;
  indicator_pkg::grades_t   g1;
  indicator_pkg::grades_t   g2;
  logic                     aim_override;
  logic                     rate_test;
  logic [6:0]               rate_pct;
  logic                     green_led_r;
  logic                     red_led_r;
  logic                     aim_led_r;
  logic                     illum_en_r;
  logic                     read_accept_r;
  logic                     cycle_led_r;
  logic                     good_read_led_r;
  logic [4:0]               status_leds_r;
  logic [31:0]              seed = 32'h0000_01cf;
  logic                     mon;
  logic                     aim_q;
  logic                     act_q;
  logic                     acc_lo;
  logic                     good;
  logic                     mt;
  int                       lat;
  int                       g_cnt;
  int                       bad_count;
  int                       num_checks;

  indicator_led_ctrl #(
    .TICK_CYCLES (TICK)
  ) u_indicator_led_ctrl (
    .clk             (clk),
    .reset_n         (reset_n),
    .cfg             (cfg),
    .evt             (evt),
    .grades          (grades),
    .aim_override    (aim_override),
    .rate_test       (rate_test),
    .rate_pct        (rate_pct),
    .green_led_r     (green_led_r),
    .red_led_r       (red_led_r),
    .aim_led_r       (aim_led_r),
    .illum_en_r      (illum_en_r),
    .read_accept_r   (read_accept_r),
    .cycle_led_r     (cycle_led_r),
    .good_read_led_r (good_read_led_r),
    .status_leds_r   (status_leds_r)
  );

  read_cycle_model u_read_cycle_model (
    .clk    (clk),
    .evt    (evt),
    .grades (grades)
  );

  // ****************************************
  // expectations
  // ****************************************
  function logic [31:0] xr();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic indicator_pkg::grades_t rnd_grades();
    indicator_pkg::grades_t g;
    g.valid    = 1'b0;
    g.final_g  = indicator_pkg::grade_t'(xr() % 5);
    g.contrast = indicator_pkg::grade_t'(xr() % 5);
    g.growth   = indicator_pkg::grade_t'(xr() % 5);
    g.axial    = indicator_pkg::grade_t'(xr() % 5);
    g.ecc      = indicator_pkg::grade_t'(xr() % 5);
    return g;
  endfunction

  function automatic int exp_green(indicator_pkg::cfg_t c, logic gd,
                                   logic m, int l);
    logic t;
    case (c.flash_mode)
      indicator_pkg::FLASH_GOOD:     t = gd;
      indicator_pkg::FLASH_STATIC:   t = gd & c.continuous_read;
      indicator_pkg::FLASH_MATCH:    t = gd & (m | !c.match_enable);
      indicator_pkg::FLASH_MISMATCH: t = gd & !m & c.match_enable;
      indicator_pkg::FLASH_STROBE:   return l + 2;
      default:                       t = 1'b0;
    endcase
    return t ? int'(c.flash_hold) * TICK : 0;
  endfunction

  function automatic logic [4:0] exp_status(indicator_pkg::cfg_t c,
                                            indicator_pkg::grades_t g);
    indicator_pkg::grade_t s;
    case (c.grade_param)
      indicator_pkg::GP_CONTRAST: s = g.contrast;
      indicator_pkg::GP_GROWTH:   s = g.growth;
      indicator_pkg::GP_AXIAL:    s = g.axial;
      indicator_pkg::GP_ECC:      s = g.ecc;
      default:                    s = g.final_g;
    endcase
    return (c.led_mode == indicator_pkg::LED_GRADE) ? 5'h1f >> s : 5'h00;
  endfunction

  function automatic logic exp_aim(indicator_pkg::aim_mode_t m, logic o,
                                   logic a);
    return o | (m == indicator_pkg::AIM_ON)
      | (m == indicator_pkg::AIM_OUTSIDE & !a)
      | (m == indicator_pkg::AIM_INSIDE & a);
  endfunction

  function automatic logic [4:0] rate_bar(logic [6:0] p);
    for (int k = 0; k < 5; k++) rate_bar[k] = p >= 7'(20 * (k + 1));
  endfunction

  task automatic step;
    @(posedge clk);
    #1;
  endtask

  task automatic chk_rst;
    `CHK("reset outputs", 12'h180, {green_led_r, red_led_r, aim_led_r,
      illum_en_r, read_accept_r, cycle_led_r, good_read_led_r,
      status_leds_r})
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // pre-edge values: outputs seen here answer the previous edge's inputs
  always @(posedge clk)
  begin
    if (mon)
    begin
      if (green_led_r !== 1'b0) g_cnt++;
      if (read_accept_r !== 1'b1) acc_lo = 1'b1;
      `CHK("aim_led_r", aim_q, aim_led_r)
      `CHK("cycle_led_r", act_q, cycle_led_r)
    end
    aim_q <= exp_aim(cfg.aim_mode, aim_override, evt.cycle_active);
    act_q <= evt.cycle_active & (cfg.led_mode == indicator_pkg::LED_STANDARD);
  end

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    #(40 * 8000);
    bad_count++;
    give_verdict();
  end

  // ****************************************
  // stimulus
  // ****************************************
  initial
  begin
    reset_n      = 1'b0;
    cfg          = '0;
    aim_override = 1'b0;
    rate_test    = 1'b0;
    rate_pct     = 7'h00;
    mon          = 1'b0;
    repeat (2) step();
    chk_rst();
    repeat (2) step();
    reset_n = 1'b1;
    step();
    for (int i = 0; i < 40; i++)
    begin
      cf.flash_mode        = indicator_pkg::flash_mode_t'(xr() % 6);
      cf.aim_mode          = indicator_pkg::aim_mode_t'(xr() % 4);
      cf.flash_hold        = 16'(xr() % 4);
      cf.led_mode          = indicator_pkg::led_mode_t'(xr() % 2);
      cf.grade_param       = indicator_pkg::grade_param_t'(xr() % 5);
      cf.symbols_per_cycle = 4'(1 + xr() % 3);
      {cf.continuous_read, cf.match_enable, cf.illum_disable} = 3'(xr());
      aim_override         = 1'(xr());
      {good, mt}           = 2'(xr());
      lat                  = int'(xr() % 4);
      g1                   = rnd_grades();
      g2                   = rnd_grades();
      // corners: static without free run, zero hold, lone static read,
      // all symbols matching, lone mismatch, lone match
      if (i < 6)
      begin
        cf.flash_mode        = (i == 1) ? indicator_pkg::FLASH_GOOD
                             : (i == 4) ? indicator_pkg::FLASH_MISMATCH
                             : (i > 2)  ? indicator_pkg::FLASH_MATCH
                                        : indicator_pkg::FLASH_STATIC;
        cf.continuous_read   = (i == 2);
        cf.match_enable      = (i > 2);
        cf.flash_hold        = (i == 1) ? 16'h0000 : 16'h0003;
        cf.symbols_per_cycle = (i == 3) ? 4'h2 : 4'h1;
        good                 = 1'b1;
        mt                   = (i != 4);
      end
      cfg    = cf;
      repeat (2) step();
      g_cnt  = 0;
      acc_lo = 1'b0;
      mon    = 1'b1;
      u_read_cycle_model.run(good, mt, lat, g1, g2);
      repeat (16) step();
      mon = 1'b0;
      `CHK("green count", exp_green(cf, good, mt, lat),
        g_cnt)
      `CHK("accept low", (cf.flash_mode == indicator_pkg::FLASH_STATIC)
        & cf.continuous_read & good & (cf.symbols_per_cycle <= 4'h1)
        & (cf.flash_hold != 16'h0000), acc_lo)
      `CHK("red_led_r", (cf.flash_mode == indicator_pkg::FLASH_STATIC)
        & cf.continuous_read, red_led_r)
      `CHK("illum_en_r", !((cf.flash_mode == indicator_pkg::FLASH_STROBE)
        & cf.illum_disable), illum_en_r)
      `CHK("status_leds_r", exp_status(cf, g1), status_leds_r)
      `CHK("good_read_led_r", good
        & (cf.led_mode == indicator_pkg::LED_STANDARD), good_read_led_r)
    end
    cf.led_mode = indicator_pkg::LED_STANDARD;
    cfg         = cf;
    rate_test   = 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      rate_pct = (i == 0) ? 7'h13 : (i == 1) ? 7'h64 : 7'(xr() % 101);
      repeat (2) step();
      `CHK("rate bar", rate_bar(rate_pct), status_leds_r)
    end
    reset_n = 1'b0;
    step();
    chk_rst();
    reset_n = 1'b1;
    repeat (2) step();
    `CHK("rate bar after reset", rate_bar(rate_pct), status_leds_r)
    give_verdict();
  end
endmodule
